// File: core/rst_seq_pkg.sv
// constants and types shared by the reset source sequencer
package rst_seq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int EXT_MIN_PULSE_NS = 1500;
  localparam int BOD_MIN_LOW_NS   = 2000;
  localparam int BANDGAP_START_US = 70;
  // least times round up to whole cycles
  localparam int EXT_CYC = (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOD_CYC = (BOD_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_W  = 5;
  localparam logic [FILT_W-1:0] EXT_CYC_V = FILT_W'(EXT_CYC);
  localparam logic [FILT_W-1:0] BOD_CYC_V = FILT_W'(BOD_CYC);
  localparam int STARTUP_BASE_CYC = 64;
  localparam int WDOG_BASE_TICKS  = 16384;
  localparam int WDOG_PERIODS     = 8;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CAUSE_OFS  = 12'h000;
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 12'h004;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h008;
  localparam int FLAG_POR  = 0;
  localparam int FLAG_EXT  = 1;
  localparam int FLAG_BOR  = 2;
  localparam int FLAG_WDOG = 3;
  localparam int CTRL_WDP_LSB  = 0;
  localparam int CTRL_WDE_BIT  = 3;
  localparam int CTRL_CMP_BANDGAP_SELECT_BIT = 6;
  localparam int STAT_LVL_LSB  = 0;
  localparam int STAT_BG_BIT   = 2;
  localparam int STAT_WDEN_BIT = 3;
  localparam int STAT_RUN_BIT  = 4;
  localparam logic [7:0] CAUSE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [1:0] SAFETY_L0 = 2'h0;
  localparam logic [1:0] SAFETY_L1 = 2'h1;
  localparam logic [1:0] SAFETY_L2 = 2'h2;

  typedef enum logic [1:0] {SEQ_HOLD, SEQ_DELAY, SEQ_RUN} seq_state_e;

endpackage : rst_seq_pkg

// File: core/wdog_if.sv
// link between the sequencer and its watchdog counter
`timescale 1ns/100ps
interface wdog_if;
  logic       tick;
  logic       restart;
  logic [2:0] period;
  logic       timeout;
  modport ctl (output tick, output restart, output period, input timeout);
  modport cnt (input tick, input restart, input period, output timeout);
endinterface : wdog_if

// File: core/wdog_counter.sv
// watchdog period counter running on oscillator ticks
`timescale 1ns/100ps
module wdog_counter
  import rst_seq_pkg::*;
#(
  parameter int TICK_W     = 22,
  parameter int BASE_TICKS = rst_seq_pkg::WDOG_BASE_TICKS
)(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  wdog_if.cnt       wd
);
  import rst_seq_pkg::*;

  logic [TICK_W-1:0] cnt_r;
  logic [TICK_W-1:0] cnt_nxt;
  logic              tmo_r;
  logic              tmo_nxt;
  logic [TICK_W-1:0] lastTick;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  // one of eight periods, base ticks doubled per step
  always_comb
  begin
    lastTick = (TICK_W'(BASE_TICKS) << wd.period) - TICK_W'(1);
    cnt_nxt  = cnt_r;
    tmo_nxt  = 1'b0;
    if (wd.restart)
    begin
      cnt_nxt = '0;
    end
    else if (wd.tick)
    begin
      if (cnt_r == lastTick)
      begin
        cnt_nxt = '0;
        tmo_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + TICK_W'(1);
      end
    end
  end

  // registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      tmo_r <= 1'b0;
    end
    else if (ce)
    begin
      cnt_r <= cnt_nxt;
      tmo_r <= tmo_nxt;
    end
  end

  assign wd.timeout = tmo_r;

  a_wdog_restart: assert property (@(posedge clk) disable iff (rst)
    ce && wd.restart |=> cnt_r == '0 && !tmo_r)
    else $error("watchdog count not cleared on restart");

  a_wdog_expiry: assert property (@(posedge clk) disable iff (rst)
    ce && wd.tick && !wd.restart && cnt_r == lastTick |=> tmo_r && cnt_r == '0)
    else $error("watchdog period expiry missed");

endmodule : wdog_counter

// File: core/reset_source_sequencer.sv
// chip reset sequencer: reset sources, start-up delay, cause flags, watchdog
// Summary of operation
// - reset held while supply below power-on level
// - rising supply starts delay, reset until expiry
// - supply drop reasserts reset with no delay
// - long low on reset pin resets
// - pin release waits full start-up delay
// - brown-out level chosen by level fuse
// - brown-out reset only when enable fuse set
// - short brown-out dips are ignored
// - brown-out recovery waits full start-up delay
// - watchdog gives one-cycle pulse, delay follows
// - watchdog flag set by watchdog, cleared by power-on or software
// - brown-out flag set by brown-out reset
// - pin flag set by pin reset
// - power-on flag cleared only by software
// - bandgap on for brown-out or comparator select
// - watchdog counts own one megahertz oscillator
// - eight watchdog periods, expiry resets chip
// - always-on fuse gives level two, enabled
// - levels zero and one start disabled
// - delay starts after all sources inactive
// - port pins reset at once, no clock
`timescale 1ns/100ps
module reset_source_sequencer
  import rst_seq_pkg::*;
#(
  parameter int DLY_W        = 24,
  parameter int STARTUP_BASE = rst_seq_pkg::STARTUP_BASE_CYC,
  parameter int WDOG_BASE    = rst_seq_pkg::WDOG_BASE_TICKS
)(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      supplyBelowPor,
  input  wire logic                      extRstPinN,
  input  wire logic                      brownoutBelow,
  input  wire logic                      brownoutEnableFuse,
  input  wire logic                      brownoutLevelFuse,
  input  wire logic                      wdogAlwaysOnFuse,
  input  wire logic                      compatModeFuse,
  input  wire logic [3:0]                clockSelectFuses,
  input  wire logic                      wdogOscTick,
  input  wire logic                      wdogRestartInstr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [rst_seq_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           chipReset,
  output logic                           portReset,
  output logic                           brownoutLevelHigh,
  output logic                           bandgapEnable,
  output logic [1:0]                     safetyLevel,
  output logic                           wdogEnabled
);
  import rst_seq_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wdog_if wd ();

  logic [FILT_W-1:0] extCnt_r;
  logic [FILT_W-1:0] extCnt_nxt;
  logic [FILT_W-1:0] bodCnt_r;
  logic [FILT_W-1:0] bodCnt_nxt;
  logic              extActive;
  logic              bodActive;
  logic              wdogPulse;
  logic              anySource;
  seq_state_e        state_r;
  seq_state_e        state_nxt;
  logic [DLY_W-1:0]  dlyCnt_r;
  logic [DLY_W-1:0]  dlyCnt_nxt;
  logic [DLY_W-1:0]  dlyLoad;
  logic [7:0]        cause_r;
  logic [7:0]        cause_nxt;
  logic [7:0]        ctrl_r;
  logic [7:0]        ctrl_nxt;
  logic [31:0]       prdata_r;
  logic [31:0]       prdata_nxt;
  logic [7:0]        statusVal;
  logic              wrAccess;
  logic              setupRd;
  logic              hitCause;
  logic              hitCtrl;
  logic              hitStatus;
  logic              mapped;

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  // pin and brown-out low-time filters, saturating counters
  always_comb
  begin
    extCnt_nxt = extCnt_r;
    bodCnt_nxt = bodCnt_r;
    if (extRstPinN)
    begin
      extCnt_nxt = '0;
    end
    else if (extCnt_r != EXT_CYC_V)
    begin
      extCnt_nxt = extCnt_r + FILT_W'(1);
    end
    if (!brownoutBelow || !brownoutEnableFuse)
    begin
      bodCnt_nxt = '0;
    end
    else if (bodCnt_r != BOD_CYC_V)
    begin
      bodCnt_nxt = bodCnt_r + FILT_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      extCnt_r <= '0;
      bodCnt_r <= '0;
    end
    else if (ce)
    begin
      extCnt_r <= extCnt_nxt;
      bodCnt_r <= bodCnt_nxt;
    end
  end

  // source levels; release of pin or supply drops them at once
  assign extActive = !extRstPinN && (extCnt_r == EXT_CYC_V);
  assign bodActive = brownoutEnableFuse && brownoutBelow
                     && (bodCnt_r == BOD_CYC_V);
  assign wdogPulse = wd.timeout;
  assign anySource = supplyBelowPor || extActive || bodActive || wdogPulse;

  // comparator level select, high level when fuse programmed
  assign brownoutLevelHigh = brownoutLevelFuse;

  // ----------------------------------------------------------------
  // start-up delay sequencer
  // ----------------------------------------------------------------
  // delay length doubles per clock-select step
  always_comb
  begin
    dlyLoad    = (DLY_W'(STARTUP_BASE) << clockSelectFuses[2:0]) - DLY_W'(1);
    state_nxt  = state_r;
    dlyCnt_nxt = dlyCnt_r;
    case (state_r)
      SEQ_HOLD:
      begin
        if (!anySource)
        begin
          state_nxt  = SEQ_DELAY;
          dlyCnt_nxt = dlyLoad;
        end
      end
      SEQ_DELAY:
      begin
        if (anySource)
        begin
          state_nxt = SEQ_HOLD;
        end
        else if (dlyCnt_r == '0)
        begin
          state_nxt = SEQ_RUN;
        end
        else
        begin
          dlyCnt_nxt = dlyCnt_r - DLY_W'(1);
        end
      end
      SEQ_RUN:
      begin
        if (anySource)
        begin
          state_nxt = SEQ_HOLD;
        end
      end
      default:
      begin
        state_nxt = SEQ_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r  <= SEQ_HOLD;
      dlyCnt_r <= '0;
    end
    else if (ce)
    begin
      state_r  <= state_nxt;
      dlyCnt_r <= dlyCnt_nxt;
    end
  end

  // chip reset asserted straight from the sources, released by the clocked state; port reset follows the sources
  assign chipReset = anySource || (state_r != SEQ_RUN);
  assign portReset = anySource;

  // ----------------------------------------------------------------
  // watchdog control
  // ----------------------------------------------------------------
  always_comb
  begin
    if (wdogAlwaysOnFuse)
    begin
      safetyLevel = SAFETY_L2;
    end
    else if (compatModeFuse)
    begin
      safetyLevel = SAFETY_L0;
    end
    else
    begin
      safetyLevel = SAFETY_L1;
    end
  end

  // level two cannot be switched off; others start off
  assign wdogEnabled = wdogAlwaysOnFuse || ctrl_r[CTRL_WDE_BIT];
  assign wd.tick     = wdogOscTick;
  assign wd.period   = ctrl_r[CTRL_WDP_LSB +: 3];
  assign wd.restart  = wdogRestartInstr || !wdogEnabled || chipReset;

  wdog_counter #(
    .TICK_W     (22),
    .BASE_TICKS (WDOG_BASE)
  ) u_wdog (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .wd  (wd.cnt)
  );

  // bandgap needed by brown-out or comparator
  assign bandgapEnable = brownoutEnableFuse || ctrl_r[CTRL_CMP_BANDGAP_SELECT_BIT];

  // ----------------------------------------------------------------
  // register file and apb slave
  // ----------------------------------------------------------------
  always_comb
  begin
    hitCause  = 1'b0;
    hitCtrl   = 1'b0;
    hitStatus = 1'b0;
    if (paddr == CAUSE_OFS)
    begin
      hitCause = 1'b1;
    end
    else if (paddr == CTRL_OFS)
    begin
      hitCtrl = 1'b1;
    end
    else if (paddr == STATUS_OFS)
    begin
      hitStatus = 1'b1;
    end
  end

  assign mapped   = hitCause || hitCtrl || hitStatus;
  assign wrAccess = psel && penable && pwrite && pstrb[0];
  assign setupRd  = psel && !penable && !pwrite;

  always_comb
  begin
    statusVal                           = 8'h00;
    statusVal[STAT_LVL_LSB +: 2]        = safetyLevel;
    statusVal[STAT_BG_BIT]              = bandgapEnable;
    statusVal[STAT_WDEN_BIT]            = wdogEnabled;
    statusVal[STAT_RUN_BIT]             = (state_r == SEQ_RUN);
  end

  // flags: software writes zero to clear, hardware set wins
  always_comb
  begin
    cause_nxt = cause_r;
    ctrl_nxt  = ctrl_r;
    if (wrAccess && hitCause)
    begin
      cause_nxt[3:0] = cause_r[3:0] & pwdata[3:0];
    end
    if (wrAccess && hitCtrl)
    begin
      ctrl_nxt = pwdata[7:0] & 8'h4f;
    end
    if (chipReset)
    begin
      ctrl_nxt = CTRL_RST;
    end
    if (wdogPulse)
    begin
      cause_nxt[FLAG_WDOG] = 1'b1;
    end
    if (bodActive)
    begin
      cause_nxt[FLAG_BOR] = 1'b1;
    end
    if (extActive)
    begin
      cause_nxt[FLAG_EXT] = 1'b1;
    end
    if (supplyBelowPor)
    begin
      cause_nxt[FLAG_POR]  = 1'b1;
      cause_nxt[FLAG_EXT]  = 1'b0;
      cause_nxt[FLAG_BOR]  = 1'b0;
      cause_nxt[FLAG_WDOG] = 1'b0;
    end
  end

  // read data captured in the setup cycle
  always_comb
  begin
    prdata_nxt = prdata_r;
    if (setupRd)
    begin
      prdata_nxt = 32'h0000_0000;
      if (hitCause)
      begin
        prdata_nxt[7:0] = cause_r;
      end
      else if (hitCtrl)
      begin
        prdata_nxt[7:0] = ctrl_r;
      end
      else if (hitStatus)
      begin
        prdata_nxt[7:0] = statusVal;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cause_r  <= CAUSE_RST;
      ctrl_r   <= CTRL_RST;
      prdata_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      cause_r  <= cause_nxt;
      ctrl_r   <= ctrl_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_por_holds_rst: assert property (@(posedge clk) disable iff (rst)
    supplyBelowPor |-> chipReset && portReset)
    else $error("power-on level did not hold reset");

  a_ext_long_low: assert property (@(posedge clk) disable iff (rst)
    !extRstPinN && extCnt_r == EXT_CYC_V |-> chipReset && portReset)
    else $error("long pin low did not reset");

  a_release_delay: assert property (@(posedge clk) disable iff (rst)
    ce && state_r == SEQ_HOLD && !anySource |=> state_r == SEQ_DELAY && dlyCnt_r == $past(dlyLoad))
    else $error("delay counter not started after sources went idle");

  a_run_via_delay: assert property (@(posedge clk) disable iff (rst)
    $rose(state_r == SEQ_RUN) |-> $past(state_r) == SEQ_DELAY && $past(dlyCnt_r) == '0)
    else $error("reset released before delay expired");

  a_bod_gated: assert property (@(posedge clk) disable iff (rst)
    !brownoutEnableFuse |-> !bodActive && bodCnt_r == '0)
    else $error("brown-out active with detector disabled");

  a_bod_short_dip: assert property (@(posedge clk) disable iff (rst)
    ce && $rose(brownoutBelow) && brownoutEnableFuse |-> !bodActive ##1 !bodActive)
    else $error("brown-out dip acted too soon");

  a_wdog_one_cycle: assert property (@(posedge clk) disable iff (rst)
    wdogPulse |-> chipReset ##1 !wdogPulse)
    else $error("watchdog reset pulse longer than one cycle");

  a_por_flags: assert property (@(posedge clk) disable iff (rst)
    ce && supplyBelowPor |=> cause_r[3:0] == 4'h1)
    else $error("power-on did not set its flag and clear others");

  a_wdog_flag_set: assert property (@(posedge clk) disable iff (rst)
    ce && wdogPulse && !supplyBelowPor |=> cause_r[FLAG_WDOG])
    else $error("watchdog flag not set");

  a_lvl2_enabled: assert property (@(posedge clk) disable iff (rst)
    wdogAlwaysOnFuse |-> wdogEnabled && safetyLevel == SAFETY_L2)
    else $error("always-on fuse did not force watchdog on");

  a_bandgap_off: assert property (@(posedge clk) disable iff (rst)
    !brownoutEnableFuse && !ctrl_r[CTRL_CMP_BANDGAP_SELECT_BIT] |-> !bandgapEnable)
    else $error("bandgap on with no user");

endmodule : reset_source_sequencer

// File: bench/supply_model.sv
// supply comparators, external reset pin and watchdog oscillator model
`timescale 1ns/100ps
module supply_model (
  input  wire logic clk,
  input  wire logic porReq,
  input  wire logic pinReq,
  input  wire logic bodReq,
  output logic      supplyBelowPor,
  output logic      extRstPinN,
  output logic      brownoutBelow,
  output logic      wdogOscTick
);
  logic [3:0] divCnt_r = 4'h0;

  // comparator levels follow the requested supply state
  assign supplyBelowPor = porReq;
  assign brownoutBelow  = bodReq;
  assign extRstPinN     = ~pinReq;  // pulled high when nobody holds it low

  // free running oscillator, one tick every ten system cycles
  always_ff @(posedge clk)
  begin
    divCnt_r <= (divCnt_r == 4'h9) ? 4'h0 : divCnt_r + 4'h1;
  end
  assign wdogOscTick = (divCnt_r == 4'h9);
endmodule : supply_model

// File: bench/testbench.sv
// self-checking bench for the reset source sequencer
`timescale 1ns/100ps
module testbench;
  import rst_seq_pkg::*;
  localparam int SB = 4;
  localparam int WB = 16;
  logic              clk = 1'b0, rst = 1'b1;
  logic              porReq = 1'b1, pinReq = 1'b0, bodReq = 1'b0;
  logic              brownout_enable_fuse = 1'b0, bodLvl = 1'b0, wdOn = 1'b0, compat = 1'b0;
  logic              ce = 1'b1;
  logic [3:0]        clock_select_fuses = 4'h0;
  logic              wdRestart = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata;
  logic              pready, pslverr, chipReset, portReset, lvlHigh, bgEn, wdEn;
  logic [1:0]        safety;
  logic              supplyBelowPor, extRstPinN, brownoutBelow, wdogOscTick;
  logic [32:0]       expQ[$];
  int                errors = 0, n_checks = 0, n, i;

  // clock generation
  always #50 clk = ~clk;

  supply_model sup_u (.clk(clk), .porReq(porReq), .pinReq(pinReq), .bodReq(bodReq),
    .supplyBelowPor(supplyBelowPor), .extRstPinN(extRstPinN),
    .brownoutBelow(brownoutBelow), .wdogOscTick(wdogOscTick));

  reset_source_sequencer #(.STARTUP_BASE(SB), .WDOG_BASE(WB)) dut_u (
    .clk(clk), .rst(rst), .ce(ce), .supplyBelowPor(supplyBelowPor),
    .extRstPinN(extRstPinN), .brownoutBelow(brownoutBelow),
    .brownoutEnableFuse(brownout_enable_fuse), .brownoutLevelFuse(bodLvl), .wdogAlwaysOnFuse(wdOn),
    .compatModeFuse(compat), .clockSelectFuses(clock_select_fuses), .wdogOscTick(wdogOscTick),
    .wdogRestartInstr(wdRestart), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chipReset(chipReset), .portReset(portReset),
    .brownoutLevelHigh(lvlHigh), .bandgapEnable(bgEn), .safetyLevel(safety),
    .wdogEnabled(wdEn));

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic conclude();
    errors += expQ.size();  // reads never answered
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // level compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // read result compare, error flag on top of data
  task automatic chkRd(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t rd=%h exp=%h", $time, got, exp);
    end
  endtask : chkRd

  // monitor takes the oldest note whenever a read completes
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
      chkRd({pslverr, prdata}, expQ.pop_front());
  end

  // ----------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // one apb transfer; last low keeps psel up for a back-to-back setup
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [32:0] exp, input logic last);
    int k;
    if (!wr)
      expQ.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      errors++;
      conclude();
    end
    penable <= 1'b0;
    if (last)
    begin
      psel <= 1'b0;
      @(posedge clk);  // idle edge, psel never set twice in one step
    end
  endtask : apb

  // counts edges until the chip reset drops, checks the stretch
  task automatic relWait(input int len = SB);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (chipReset !== 1'b0 && n < 100);
    if (n >= 100)
    begin
      errors++;
      conclude();
    end
    chk(n >= len && n <= len + 3, 1'b1);
  endtask : relWait

  // overall hang limit
  initial
  begin
    cyc(50000);
    errors++;
    conclude();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n = $urandom(71493);
    cyc(20);
    rst <= 1'b0;
    cyc(10);
    chk(chipReset, 1'b1);
    chk(portReset, 1'b1);
    porReq <= 1'b0;
    relWait();
    apb(1'b0, CAUSE_OFS, 32'h0, 33'h0_0000_0001, 1'b1);
    apb(1'b1, CAUSE_OFS, $urandom & 32'hFFFF_FFF0, 33'h0, 1'b1);
    // pin pulses, short one filtered, long one resets
    pinReq <= 1'b1;
    cyc(EXT_CYC - 2);
    pinReq <= 1'b0;
    cyc(3);
    chk(chipReset, 1'b0);
    pinReq <= 1'b1;
    cyc(EXT_CYC + 3);
    chk(chipReset, 1'b1);
    pinReq <= 1'b0;
    relWait();
    // brown-out ignored with fuse off, short dip ignored, long dip resets
    bodReq <= 1'b1;
    cyc(BOD_CYC + 10);
    chk(chipReset, 1'b0);
    chk(bgEn, 1'b0);
    bodReq <= 1'b0;
    brownout_enable_fuse <= 1'b1;
    cyc(2);
    chk(bgEn, 1'b1);
    bodReq <= 1'b1;
    cyc(BOD_CYC - 1);
    bodReq <= 1'b0;
    cyc(3);
    chk(chipReset, 1'b0);
    bodReq <= 1'b1;
    cyc(BOD_CYC + 5);
    chk(chipReset, 1'b1);
    bodReq <= 1'b0;
    relWait();
    brownout_enable_fuse <= 1'b0;
    apb(1'b0, CAUSE_OFS, 32'h0, 33'h0_0000_0006, 1'b1);
    apb(1'b1, CAUSE_OFS, 32'h0000_0004, 33'h0, 1'b1);
    apb(1'b0, CAUSE_OFS, 32'h0, 33'h0_0000_0004, 1'b1);
    // fuse decoding
    for (i = 0; i < 4; i++)
    begin
      {wdOn, compat} <= 2'(i);
      bodLvl <= i[0];
      cyc(2);
      chk(lvlHigh, i[0]);
      chk(safety, i[1] ? 2 : (i[0] ? 0 : 1));
      chk(wdEn, i[1]);
    end
    {wdOn, compat} <= 2'h0;
    // comparator bandgap select, status and control read back to back
    apb(1'b1, CTRL_OFS, 32'h0000_0040, 33'h0, 1'b1);
    cyc(BANDGAP_START_US * 1000 / CLK_PERIOD_NS);
    chk(bgEn, 1'b1);
    apb(1'b0, STATUS_OFS, 32'h0, 33'h0_0000_0015, 1'b0);
    apb(1'b0, CTRL_OFS, 32'h0, 33'h0_0000_0040, 1'b1);
    // watchdog held off by restarts, then left to expire
    apb(1'b1, CTRL_OFS, 32'h0000_0008, 33'h0, 1'b1);
    repeat (5)
    begin
      cyc(100);
      wdRestart <= 1'b1;
      cyc(1);
      wdRestart <= 1'b0;
    end
    apb(1'b0, CAUSE_OFS, 32'h0, 33'h0_0000_0004, 1'b1);
    n = 0;
    while (chipReset !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 400)
    begin
      errors++;
      conclude();
    end
    chk(n >= (WB - 2) * 10 && n <= (WB + 1) * 10, 1'b1);
    relWait();
    apb(1'b0, CAUSE_OFS, 32'h0, 33'h0_0000_000C, 1'b0);
    apb(1'b0, CTRL_OFS, 32'h0, 33'h0, 1'b1);
    // supply drop resets at once and clears the other causes
    porReq <= 1'b1;
    clock_select_fuses <= 4'h9;  // bit 3 unused, delay one step longer
    @(negedge clk);
    chk(chipReset, 1'b1);
    cyc(5);
    porReq <= 1'b0;
    relWait(SB << 1);
    apb(1'b0, CAUSE_OFS, 32'h0, 33'h0_0000_0001, 1'b1);
    // frozen clock enable stores nothing
    ce <= 1'b0;
    apb(1'b1, CTRL_OFS, 32'h0000_0048, 33'h0, 1'b1);
    ce <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0, 33'h0, 1'b1);
    chk(bgEn, 1'b0);
    // unmapped word is refused
    apb(1'b0, 12'h00C | 12'($urandom & 32'h0000_0FF0), 32'h0, 33'h1_0000_0000, 1'b1);
    cyc(2);
    conclude();
  end
endmodule : testbench
